// ===== rtl/crf_defines.vh
`ifndef CRF_DEFINES_VH
`define CRF_DEFINES_VH

// ----------------------------------------------------------------
// record type codes
// ----------------------------------------------------------------
`define CRF_OLD_STYLE_RECORD_CODE      7'h00
`define CRF_POS_HDLC_CODE              7'h01
`define CRF_ETHERNET_RECORD_CODE       7'h02
`define CRF_ATM_CELL_RECORD_CODE       7'h03
`define CRF_AAL5_FRAME_RECORD_CODE     7'h04
`define CRF_MC_HDLC_CODE               7'h05
`define CRF_MC_TIMESLOT_CODE           7'h06
`define CRF_MC_ATM_CODE                7'h07
`define CRF_MC_RAW_LINK_CODE           7'h08
`define CRF_MC_AAL5_CODE               7'h09
`define CRF_TAGGED_HDLC_CODE           7'h0A
`define CRF_TAGGED_ETHERNET_CODE       7'h0B
`define CRF_MC_AAL2_CODE               7'h0C
`define CRF_IP_COUNT_RECORD_CODE       7'h0D
`define CRF_TCP_FLOW_COUNT_CODE        7'h0E
`define CRF_DSM_TAGGED_HDLC_CODE       7'h0F
`define CRF_DSM_TAGGED_ETHERNET_CODE   7'h10
`define CRF_TAGGED_MC_HDLC_CODE        7'h11
`define CRF_AAL2_FRAME_CODE            7'h12
`define CRF_HASHED_TAGGED_HDLC_CODE    7'h13
`define CRF_HASHED_TAGGED_ETHERNET_CODE 7'h14
`define CRF_INFINIBAND_CODE            7'h15
`define CRF_IPV4_CODE                  7'h16
`define CRF_IPV6_CODE                  7'h17
`define CRF_RAW_LINK_CODE              7'h18
`define CRF_RESERVED_LO_CODE           7'h20
`define CRF_RESERVED_HI_CODE           7'h2F
`define CRF_PAD_RECORD_CODE            7'h30

// ----------------------------------------------------------------
// record layout
// ----------------------------------------------------------------
`define CRF_EXT_FLAG_BIT      7
`define CRF_FIXED_HDR_BYTES   16'h0010
`define CRF_EXT_HDR_BYTES     16'h0008
`define CRF_OFFSET_PAD_BYTES  16'h0002
`define CRF_OFFSET_BYTE_VAL   8'h00
`define CRF_PAD_BYTE_VAL      8'h00
`define CRF_HDR_LAST_IDX      4'hF
`define CRF_EXT_LAST_IDX      3'h7
`define CRF_FIFO_WIDTH        9
`define CRF_FIFO_DEPTH        8
`define CRF_FIFO_AW           3

`endif

// ===== rtl/crf_fifo.v
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// small synchronous fifo with registered read data
// ----------------------------------------------------------------
module crf_fifo
#(
   parameter WIDTH = 9,
   parameter DEPTH = 8,
   parameter AW    = 3
)
(
   input  wire             clk_in,
   input  wire             rst_in,
   input  wire [WIDTH-1:0] wr_data_in,
   input  wire             wr_valid_in,
   output wire             wr_ready_out,
   output reg  [WIDTH-1:0] rd_data_out,
   output reg              rd_valid_out,
   input  wire             rd_ready_in
);

   reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
   reg [AW-1:0]    wptr_reg;
   reg [AW-1:0]    rptr_reg;
   reg [AW:0]      count_reg;
   wire            do_wr;
   wire            do_rd;
   wire            out_free;

   // output stage is free when empty or being drained
   assign out_free     = !rd_valid_out || rd_ready_in;
   assign do_rd        = out_free && (count_reg != {(AW+1){1'b0}});
   assign wr_ready_out = (count_reg != DEPTH[AW:0] + {AW+1{1'b0}}) || do_rd;
   assign do_wr        = wr_valid_in && wr_ready_out;

   // storage write
   always @(posedge clk_in)
   begin
      if (do_wr)
         mem_reg[wptr_reg] <= wr_data_in;
   end

   // pointers, count and output register
   always @(posedge clk_in)
   begin
      if (rst_in)
      begin
         wptr_reg     <= {AW{1'b0}};
         rptr_reg     <= {AW{1'b0}};
         count_reg    <= {(AW+1){1'b0}};
         rd_valid_out <= 1'b0;
         rd_data_out  <= {WIDTH{1'b0}};
      end
      else
      begin
         if (do_wr)
            wptr_reg <= wptr_reg + 1'b1;
         if (do_rd)
         begin
            rptr_reg    <= rptr_reg + 1'b1;
            rd_data_out <= mem_reg[rptr_reg];
         end
         if (do_rd)
            rd_valid_out <= 1'b1;
         else if (rd_ready_in)
            rd_valid_out <= 1'b0;
         if (do_wr && !do_rd)
            count_reg <= count_reg + 1'b1;
         else if (do_rd && !do_wr)
            count_reg <= count_reg - 1'b1;
      end
   end

endmodule // crf_fifo

`default_nettype wire

// ===== rtl/crf_formatter.v
`timescale 1ns/1ps
`default_nettype none
`include "crf_defines.vh"

// How it works
// [RQ1] Type byte bit 7 is one when one or more extension headers follow the fixed header.
// [RQ2] The low seven type bits carry the code, 2 for a plain Ethernet capture record.
// [RQ3] Codes 0, 1, 3 and 4 are legacy, POS HDLC, single ATM cell and AAL5 frame.
// [RQ4] Multi-channel codes are 5 HDLC, 6 time slot, 7 ATM, 8 raw link, 9 AAL5, 12 AAL2.
// [RQ5] Codes 10 and 11 are the HDLC and Ethernet layouts with a color tag for the drop count.
// [RQ6] Codes 15 and 16 carry a DSM color there, and 17 is a colored multi-channel HDLC.
// [RQ7] Code 13 is an IP counter, 14 a TCP flow counter and 18 a reassembled AAL2 frame.
// [RQ8] Code 19 is hashed colored POS HDLC and 20 its hashed colored Ethernet equivalent.
// [RQ9] Codes 21, 22, 23 are InfiniBand, IPv4, IPv6 and 24 is raw SONET or SDH link data.
// [RQ10] Codes 32 to 47 are never emitted and 48 marks a padding record.
// [RQ11] The consumer ignores the offset byte, whose content is undefined.
// [RQ12] One pad byte sits directly before the frame so its layer 3 header is word aligned.
// [RQ13] Payload length is record length minus 16, minus extension headers, minus 2.
// [RQ14] The record length field is exact, so the next record starts that many bytes later.
// [RQ15] The drop count field counts frames dropped toward the host since the last record; here the counter restarts only at uncolored records.
// [RQ16] Each extension header is 8 bytes and its bit 7 flags another one following.
module crf_formatter
(
   input  wire        clk_in,
   input  wire        rst_in,
   // record request
   input  wire        start_in,
   output wire        start_ready_out,
   input  wire [6:0]  code_in,
   input  wire [63:0] timestamp_in,
   input  wire [7:0]  flags_in,
   input  wire [15:0] color_in,
   input  wire [15:0] wire_len_in,
   input  wire [2:0]  ext_count_in,
   input  wire [15:0] payload_len_in,
   // extension header words, one per header
   input  wire [63:0] ext_word_in,
   output wire        ext_take_out,
   // payload bytes
   input  wire [7:0]  pay_data_in,
   input  wire        pay_valid_in,
   output wire        pay_ready_out,
   // frame dropped before reaching the host
   input  wire        drop_in,
   // record byte stream toward host buffer
   output wire [7:0]  rec_data_out,
   output wire        rec_last_out,
   output wire        rec_valid_out,
   input  wire        rec_ready_in,
   output reg         code_error_out
);

   // ----------------------------------------------------------------
   // states
   // ----------------------------------------------------------------
   // one-hot state codes
   localparam [4:0] ST_IDLE = 5'h01;
   localparam [4:0] ST_HDR  = 5'h02;
   localparam [4:0] ST_EXT  = 5'h04;
   localparam [4:0] ST_OFS  = 5'h08;
   localparam [4:0] ST_PAY  = 5'h10;

   reg  [4:0]   state_reg;
   reg  [4:0]   state_next;
   reg  [3:0]   idx_reg;
   reg  [3:0]   idx_next;
   reg  [2:0]   ext_left_reg;
   reg  [2:0]   ext_left_next;
   reg  [15:0]  pay_left_reg;
   reg  [15:0]  pay_left_next;
   reg  [127:0] hdr_reg;
   reg  [127:0] hdr_next;
   reg  [63:0]  ext_reg;
   reg  [63:0]  ext_next;
   reg  [15:0]  drops_reg;
   reg  [15:0]  drops_next;
   reg          err_next;
   reg  [7:0]   byte_out;
   reg          last_out;
   reg          push;
   wire         fifo_ready;
   wire [8:0]   fifo_rd;
   wire         code_ok;
   wire         colored;
   wire [15:0]  rec_len;
   wire [15:0]  lctr_val;
   wire [7:0]   type_byte;

   // ----------------------------------------------------------------
   // header field assembly
   // ----------------------------------------------------------------

   // reserved band and out-of-table codes refused
   // [RQ3] single link codes
   // [RQ4] multi-channel codes
   // [RQ7] counter and aal2 codes
   // [RQ9] variable length codes
   // [RQ10] reserved codes blocked
   assign code_ok = (code_in <= `CRF_RAW_LINK_CODE) || (code_in == `CRF_PAD_RECORD_CODE);

   // [RQ5] color replaces drop count
   // [RQ6] dsm colored layouts
   // [RQ8] hashed colored layouts
   assign colored = (code_in == `CRF_TAGGED_HDLC_CODE)
                 || (code_in == `CRF_TAGGED_ETHERNET_CODE)
                 || (code_in == `CRF_DSM_TAGGED_HDLC_CODE)
                 || (code_in == `CRF_DSM_TAGGED_ETHERNET_CODE)
                 || (code_in == `CRF_TAGGED_MC_HDLC_CODE)
                 || (code_in == `CRF_HASHED_TAGGED_HDLC_CODE)
                 || (code_in == `CRF_HASHED_TAGGED_ETHERNET_CODE);

   // [RQ15] drop count or color
   assign lctr_val = colored ? color_in : drops_reg;

   // [RQ14] exact record length
   assign rec_len = `CRF_FIXED_HDR_BYTES + {10'h000, ext_count_in, 3'h0}
                  + `CRF_OFFSET_PAD_BYTES + payload_len_in;

   // [RQ1] extension present flag
   // [RQ2] code in low seven bits
   assign type_byte = {(ext_count_in != 3'h0), code_in};

   // ----------------------------------------------------------------
   // handshakes toward the sources
   // ----------------------------------------------------------------
   // idle alone takes a request
   assign start_ready_out = (state_reg == ST_IDLE);
   assign ext_take_out    = (state_reg == ST_EXT) && (idx_reg == 4'h0) && fifo_ready;
   assign pay_ready_out   = (state_reg == ST_PAY) && fifo_ready;

   // ----------------------------------------------------------------
   // next state and byte selection
   // ----------------------------------------------------------------
   // next state, byte and push
   always @*
   begin
      state_next    = state_reg;
      idx_next      = idx_reg;
      ext_left_next = ext_left_reg;
      pay_left_next = pay_left_reg;
      hdr_next      = hdr_reg;
      ext_next      = ext_reg;
      drops_next    = drops_reg;
      err_next      = 1'b0;
      byte_out      = 8'h00;
      last_out      = 1'b0;
      push          = 1'b0;
      // saturating drop counter, a drop meeting a start counts toward the next record
      if (drop_in && (drops_reg != 16'hFFFF))
         drops_next = drops_reg + 16'h0001;
      case (state_reg)
         ST_IDLE:
         begin
            // refuse a bad code or latch all fields
            if (start_in && !code_ok)
               err_next = 1'b1;
            else if (start_in)
            begin
               hdr_next      = {timestamp_in, type_byte, flags_in, rec_len,
                                lctr_val, wire_len_in};
               ext_left_next = ext_count_in;
               pay_left_next = payload_len_in;
               idx_next      = 4'h0;
               state_next    = ST_HDR;
               // [RQ15] counter restarts per uncolored record
               if (!colored)
                  drops_next = drop_in ? 16'h0001 : 16'h0000;
            end
         end
         ST_HDR:
         begin
            // sixteen fixed header bytes, msb first
            byte_out = hdr_reg[127:120];
            push     = 1'b1;
            if (fifo_ready)
            begin
               hdr_next = {hdr_reg[119:0], 8'h00};
               idx_next = idx_reg + 4'h1;
               if (idx_reg == `CRF_HDR_LAST_IDX)
               begin
                  idx_next   = 4'h0;
                  state_next = (ext_left_reg != 3'h0) ? ST_EXT : ST_OFS;
               end
            end
         end
         ST_EXT:
         begin
            // [RQ16] eight bytes per extension, bit 7 chains
            if (idx_reg == 4'h0)
               byte_out = {(ext_left_reg != 3'h1), ext_word_in[62:56]};
            else
               byte_out = ext_reg[63:56];
            push = 1'b1;
            if (fifo_ready)
            begin
               ext_next = (idx_reg == 4'h0) ? {ext_word_in[55:0], 8'h00}
                                            : {ext_reg[55:0], 8'h00};
               idx_next = idx_reg + 4'h1;
               // last byte of this header
               if (idx_reg[2:0] == `CRF_EXT_LAST_IDX)
               begin
                  idx_next      = 4'h0;
                  ext_left_next = ext_left_reg - 3'h1;
                  if (ext_left_reg == 3'h1)
                     state_next = ST_OFS;
               end
            end
         end
         ST_OFS:
         begin
            // [RQ11] offset byte left as a constant
            // [RQ12] pad byte just before the frame
            byte_out = (idx_reg == 4'h0) ? `CRF_OFFSET_BYTE_VAL : `CRF_PAD_BYTE_VAL;
            last_out = (idx_reg == 4'h1) && (pay_left_reg == 16'h0000);
            push     = 1'b1;
            if (fifo_ready)
            begin
               idx_next = idx_reg + 4'h1;
               if (idx_reg == 4'h1)
               begin
                  idx_next   = 4'h0;
                  state_next = (pay_left_reg == 16'h0000) ? ST_IDLE : ST_PAY;
               end
            end
         end
         ST_PAY:
         begin
            // [RQ13] exactly payload_len bytes follow
            byte_out = pay_data_in;
            last_out = (pay_left_reg == 16'h0001);
            push     = pay_valid_in;
            if (pay_valid_in && fifo_ready)
            begin
               pay_left_next = pay_left_reg - 16'h0001;
               if (pay_left_reg == 16'h0001)
                  state_next = ST_IDLE;
            end
         end
         default:
         begin
            // recover from an illegal state
            state_next = ST_IDLE;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   // sync reset, then next values
   always @(posedge clk_in)
   begin
      if (rst_in)
      begin
         state_reg      <= ST_IDLE;
         idx_reg        <= 4'h0;
         ext_left_reg   <= 3'h0;
         pay_left_reg   <= 16'h0000;
         hdr_reg        <= 128'h0;
         ext_reg        <= 64'h0;
         drops_reg      <= 16'h0000;
         code_error_out <= 1'b0;
      end
      else
      begin
         state_reg      <= state_next;
         idx_reg        <= idx_next;
         ext_left_reg   <= ext_left_next;
         pay_left_reg   <= pay_left_next;
         hdr_reg        <= hdr_next;
         ext_reg        <= ext_next;
         drops_reg      <= drops_next;
         code_error_out <= err_next;
      end
   end

   // ----------------------------------------------------------------
   // output buffer
   // ----------------------------------------------------------------
   // eight deep byte buffer toward the host
   crf_fifo
   #(
      .WIDTH (`CRF_FIFO_WIDTH),
      .DEPTH (`CRF_FIFO_DEPTH),
      .AW    (`CRF_FIFO_AW)
   )
   u_fifo
   (
      .clk_in       (clk_in),
      .rst_in       (rst_in),
      .wr_data_in   ({last_out, byte_out}),
      .wr_valid_in  (push),
      .wr_ready_out (fifo_ready),
      .rd_data_out  (fifo_rd),
      .rd_valid_out (rec_valid_out),
      .rd_ready_in  (rec_ready_in)
   );

   // stored word is end flag and byte
   assign rec_data_out = fifo_rd[7:0];
   assign rec_last_out = fifo_rd[8];

endmodule // crf_formatter

`default_nettype wire

// ===== tb/crf_formatter_props.sv
`timescale 1ns/1ps
`default_nettype none
module crf_chk
(
   input wire logic        clk_in,
   input wire logic        rst_in,
   input wire logic        start_in,
   input wire logic        start_ready_out,
   input wire logic [6:0]  code_in,
   input wire logic [2:0]  ext_count_in,
   input wire logic [15:0] payload_len_in,
   input wire logic [7:0]  rec_data_out,
   input wire logic        rec_last_out,
   input wire logic        rec_valid_out,
   input wire logic        rec_ready_in,
   input wire logic        code_error_out
);
   logic [15:0] bcnt, c_len, o_len, o_ext;
   logic [6:0]  c_code;
   logic [2:0]  c_ext;
   wire take  = start_in && start_ready_out;
   wire legal = (code_in <= 7'h18) || (code_in == 7'h30);
   wire hs    = rec_valid_out && rec_ready_in;
   // byte index, request and record capture
   always @(posedge clk_in)
   begin
      if (rst_in)
         bcnt <= 16'h0000;
      else if (hs)
         bcnt <= rec_last_out ? 16'h0000 : bcnt + 16'h0001;
      if (take && legal)
      begin
         c_code <= code_in;
         c_ext  <= ext_count_in;
         c_len  <= 16'h0012 + {10'h000, ext_count_in, 3'h0} + payload_len_in;
      end
      if (hs && bcnt == 16'h0008)
      begin
         o_len <= c_len;
         o_ext <= {10'h000, c_ext, 3'h0};
      end
   end
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);
   property p_error;
      take && !legal |=> code_error_out ##1 !code_error_out;
   endproperty
   property p_accept;
      take && legal |=> !code_error_out && !start_ready_out;
   endproperty
   property p_type;
      hs && bcnt == 16'h0008 |-> rec_data_out == {c_ext != 3'h0, c_code};
   endproperty
   property p_rsvd;
      hs && bcnt == 16'h0008 |-> rec_data_out[6:4] != 3'h2;
   endproperty
   property p_rlen;
      hs && (bcnt == 16'h000A || bcnt == 16'h000B)
         |-> rec_data_out == (bcnt[0] ? o_len[7:0] : o_len[15:8]);
   endproperty
   property p_last;
      hs |-> rec_last_out == (bcnt > 16'h0008 && bcnt == o_len - 16'h0001);
   endproperty
   property p_pad;
      hs && bcnt > 16'h0008 && bcnt == 16'h0011 + o_ext |-> rec_data_out == 8'h00;
   endproperty
   property p_ext;
      hs && bcnt >= 16'h0010 && bcnt < 16'h0010 + o_ext && bcnt[2:0] == 3'h0
         |-> rec_data_out[7] == (bcnt < 16'h0008 + o_ext);
   endproperty
   property p_hold;
      rec_valid_out && !rec_ready_in
         |=> rec_valid_out && $stable(rec_data_out) && $stable(rec_last_out);
   endproperty
   property p_rst;
      disable iff (1'b0)
      rst_in |=> !rec_valid_out && !code_error_out && start_ready_out;
   endproperty
   a_error: assert property (p_error) else $error("bad code not flagged");
   a_accept: assert property (p_accept) else $error("good code refused");
   a_type: assert property (p_type) else $error("type byte wrong");
   a_rsvd: assert property (p_rsvd) else $error("reserved code sent");
   a_rlen: assert property (p_rlen) else $error("length field wrong");
   a_last: assert property (p_last) else $error("last byte misplaced");
   a_pad: assert property (p_pad) else $error("pad byte not zero");
   a_ext: assert property (p_ext) else $error("chain bit wrong");
   a_hold: assert property (p_hold) else $error("output moved in stall");
   a_rst: assert property (p_rst) else $error("reset state wrong");
   c_exthdr: cover property (take && ext_count_in != 3'h0);
   c_bad: cover property (take && !legal);
   c_stall: cover property (rec_valid_out && !rec_ready_in);
endmodule // crf_chk
bind crf_formatter crf_chk u_chk
(
   .clk_in(clk_in), .rst_in(rst_in), .start_in(start_in),
   .start_ready_out(start_ready_out), .code_in(code_in),
   .ext_count_in(ext_count_in), .payload_len_in(payload_len_in),
   .rec_data_out(rec_data_out), .rec_last_out(rec_last_out),
   .rec_valid_out(rec_valid_out), .rec_ready_in(rec_ready_in),
   .code_error_out(code_error_out)
);
`default_nettype wire

// ===== tb/crf_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module crf_host_model
(
   input  wire logic       clk_in,
   input  wire logic       rst_in,
   input  wire logic [7:0] data_in,
   input  wire logic       last_in,
   input  wire logic       valid_in,
   input  wire logic       slow_in,
   output var  logic       ready_out
);
   logic [7:0]  mem [0:2047];
   logic [31:0] n, last_at;
   // bytes stored raw
   // stores bytes, stalls every other cycle when slow
   always @(posedge clk_in)
   begin
      if (rst_in)
      begin
         n         <= 32'h00000000;
         ready_out <= 1'b0;
      end
      else
      begin
         ready_out <= slow_in ? !ready_out : 1'b1;
         if (valid_in && ready_out)
         begin
            mem[n[10:0]] <= data_in;
            n            <= n + 32'h00000001;
            if (last_in)
               last_at <= n;
         end
      end
   end
endmodule // crf_host_model
`default_nettype wire

// ===== tb/crf_formatter_test.sv
`timescale 1ns/1ps
`default_nettype none
module crf_formatter_test;
   localparam logic [63:0] TS = 64'h0123456789ABCDEF;
   logic        clk_in = 1'b0, rst_in = 1'b1, start_in = 1'b0, drop_in = 1'b0;
   logic        pay_valid_in = 1'b0, slow = 1'b0;
   logic [6:0]  code_in = 7'h00;
   logic [2:0]  ext_count_in = 3'h0;
   logic [15:0] payload_len_in = 16'h0000, color_in = 16'hBEEF;
   logic [7:0]  pcnt = 8'h00, ecnt = 8'h00;
   logic        start_ready_out, ext_take_out, pay_ready_out, rec_ready_in;
   logic        rec_last_out, rec_valid_out, code_error_out;
   logic [7:0]  rec_data_out;
   logic [6:0]  bads [5] = '{7'h19, 7'h1F, 7'h20, 7'h2F, 7'h7F};
   int          failures = 0, n_compared = 0;
   crf_formatter uut
   (
      .clk_in(clk_in), .rst_in(rst_in), .start_in(start_in),
      .start_ready_out(start_ready_out), .code_in(code_in), .timestamp_in(TS),
      .flags_in(8'h5A), .color_in(color_in), .wire_len_in(16'h0040),
      .ext_count_in(ext_count_in), .payload_len_in(payload_len_in),
      .ext_word_in({4'h0, ecnt[3:0], 56'h11223344556677}),
      .ext_take_out(ext_take_out), .pay_data_in(pcnt), .pay_valid_in(pay_valid_in),
      .pay_ready_out(pay_ready_out), .drop_in(drop_in), .rec_data_out(rec_data_out),
      .rec_last_out(rec_last_out), .rec_valid_out(rec_valid_out),
      .rec_ready_in(rec_ready_in), .code_error_out(code_error_out)
   );
   crf_host_model host
   (
      .clk_in(clk_in), .rst_in(rst_in), .data_in(rec_data_out), .last_in(rec_last_out),
      .valid_in(rec_valid_out), .slow_in(slow), .ready_out(rec_ready_in)
   );
   // clock
   always #50 clk_in = !clk_in;
   // payload and extension sources, advanced at the falling edge
   logic        p_take = 1'b0, e_take = 1'b0;
   always @(posedge clk_in)
   begin
      p_take <= pay_valid_in && pay_ready_out;
      e_take <= ext_take_out;
   end
   always @(negedge clk_in)
   begin
      if (p_take)
         pcnt <= pcnt + 8'h01;
      if (e_take)
         ecnt <= ecnt + 8'h01;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         failures++;
         $display("Error %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic stop_test;
      if (failures == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // --------
   // scenarios
   // --------
   task automatic rec(input logic [6:0] c, input int en, input int pl, input int d);
      int b, k, j, rl;
      logic [15:0] lc;
      logic [7:0] x;
      b = host.n;
      rl = 18 + 8 * en + pl;
      lc = (c inside {10, 11, 15, 16, 17, 19, 20}) ? color_in : 16'(d);
      pcnt = 8'h00;
      ecnt = 8'h00;
      code_in = c;
      ext_count_in = 3'(en);
      payload_len_in = 16'(pl);
      pay_valid_in = 1'b1;
      start_in = 1'b1;
      @(negedge clk_in) start_in = 1'b0;
      for (k = 0; k < 3000 && host.n < b + rl; k++)
         @(negedge clk_in);
      pay_valid_in = 1'b0;
      for (k = 0; k < rl; k++)
      begin
         j = k - 16;
         case (k)
            8: x = {en != 0, c};
            9: x = 8'h5A;
            10: x = 8'(rl >> 8);
            11: x = 8'(rl);
            12: x = lc[15:8];
            13: x = lc[7:0];
            14: x = 8'h00;
            15: x = 8'h40;
            default: x = k < 8 ? TS[63 - 8 * k -: 8] : j < 8 * en ?
               (j % 8 == 0 ? {j < 8 * en - 8, 3'h0, 4'(j / 8)} : 8'(17 * (j % 8))) :
               j == 8 * en ? 8'h00 : j == 8 * en + 1 ? 8'h00 : 8'(j - 8 * en - 2);
         endcase
         chk(host.mem[b + k], x);
      end
      chk(host.last_at, b + rl - 1);
   endtask
   task automatic bad(input logic [6:0] c);
      int b;
      b = host.n;
      code_in = c;
      start_in = 1'b1;
      @(negedge clk_in) start_in = 1'b0;
      chk(code_error_out, 1);
      @(negedge clk_in) chk(code_error_out, 0);
      repeat (4) @(negedge clk_in);
      chk(host.n, b);
      chk(start_ready_out, 1);
   endtask
   // main sequence
   initial
   begin
      repeat (6) @(negedge clk_in);
      rst_in = 1'b0;
      chk(start_ready_out, 1);
      repeat (3)
      begin
         drop_in = 1'b1;
         @(negedge clk_in) drop_in = 1'b0;
         @(negedge clk_in);
      end
      rec(7'h02, 0, 5, 3);
      rec(7'h02, 0, 0, 0);
      slow = 1'b1;
      rec(7'h0B, 2, 4, 0);
      rec(7'h10, 7, 1, 0);
      slow = 1'b0;
      for (int c = 0; c < 26; c++)
         rec(c == 25 ? 7'h30 : 7'(c), 0, 0, 0);
      foreach (bads[i])
         bad(bads[i]);
      stop_test;
   end
   // watchdog
   initial
   begin
      #5000000;
      failures++;
      stop_test;
   end
endmodule // crf_formatter_test
`default_nettype wire
